// >>> src/fault_timing_pkg.sv
// Constants for the port fault-timing block
package fault_timing_pkg;

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  localparam logic [7:0] FAULT_TIMEOUT_CONFIG_CMD = 8'h16;
  localparam logic [7:0] FAULT_TIMEOUT_CONFIG_RST = 8'h00;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CURRENT_LIMIT_CODE_LSB = 6;
  localparam int STARTUP_CODE_LSB       = 4;
  localparam int OVERLOAD_CODE_LSB      = 2;
  localparam int DROPOUT_CODE_LSB       = 0;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 5;
  localparam int TICK_PERIOD_NS  = 100_000;
  localparam int TICK_CYCLES     = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int COOL_DOWN_MS    = 1000;
  localparam int COOL_DOWN_TICKS = COOL_DOWN_MS * 1_000_000
                                   / TICK_PERIOD_NS;
  localparam int DECAY_DIVIDE    = 16;
  localparam int LIM_CNT_W       = 12;
  localparam int COOL_CNT_W      = 14;
  localparam int TICK_CNT_W      = 16;

endpackage

// >>> src/pse_port_fault_timing.sv
// Shared fault-timing register and per-port current-limit timers
//
// Notes on behaviour
// - Register reached by command 16h, one byte
// - One register times every port alike
// - Any timeout fault clears power-good and enable
// - Fields 7-6, 5-4, 3-2, 1-0; reset zero
// - Count up after start-up, while limiting
// - Counter at timeout switches port off
// - One-second cool-down blocks power-on
// - Below limit, decay at one sixteenth, floor zero
// - Turn-off commands and events clear counter
// - Changed limit code restarts running counters
// - Reset or off/manual cancels cool-down; restart detect
`timescale 1ns/1ps

module pse_port_fault_timing
  import fault_timing_pkg::*;
#(
  parameter int NPORTS      = 4,
  parameter int TICK_CYC    = fault_timing_pkg::TICK_CYCLES,
  parameter int COOL_TICKS  = fault_timing_pkg::COOL_DOWN_TICKS,
  parameter logic [fault_timing_pkg::LIM_CNT_W-1:0] LIM_TICKS0 = 12'd600,
  parameter logic [fault_timing_pkg::LIM_CNT_W-1:0] LIM_TICKS1 = 12'd150,
  parameter logic [fault_timing_pkg::LIM_CNT_W-1:0] LIM_TICKS2 = 12'd100,
  parameter logic [fault_timing_pkg::LIM_CNT_W-1:0] LIM_TICKS3 = 12'd60
) (
  // Clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              rst_i,
  // Management command port
  input  wire logic              cmd_valid_i,
  input  wire logic [7:0]        cmd_code_i,
  input  wire logic              cmd_write_i,
  input  wire logic [7:0]        cmd_wdata_i,
  output logic                   rsp_valid_o,
  output logic [7:0]             rsp_rdata_o,
  // Timing codes to the other port engines
  output logic [1:0]             current_limit_timeout_code_o,
  output logic [1:0]             startup_timeout_code_o,
  output logic [1:0]             overload_timeout_code_o,
  output logic [1:0]             signature_dropout_timeout_code_o,
  // Per-port status and control
  input  wire logic [NPORTS-1:0] power_on_req_i,
  input  wire logic [NPORTS-1:0] power_good_sense_i,
  input  wire logic [NPORTS-1:0] startup_done_i,
  input  wire logic [NPORTS-1:0] at_current_limit_i,
  input  wire logic [NPORTS-1:0] overload_fault_i,
  input  wire logic [NPORTS-1:0] dropout_fault_i,
  input  wire logic [NPORTS-1:0] startup_fault_i,
  input  wire logic [NPORTS-1:0] enable_off_cmd_i,
  input  wire logic [NPORTS-1:0] port_reset_cmd_i,
  input  wire logic [NPORTS-1:0] dc_disconnect_i,
  input  wire logic [NPORTS-1:0] shutdown_priority_i,
  input  wire logic [NPORTS-1:0] off_or_manual_mode_i,
  input  wire logic [NPORTS-1:0] semiauto_detect_en_i,
  // Fast shutdown pin
  input  wire logic              fast_shutdown_input_i,
  // Per-port outputs
  output logic [NPORTS-1:0]      port_power_good_bit_o,
  output logic [NPORTS-1:0]      port_power_enable_bit_o,
  output logic [NPORTS-1:0]      cool_down_active_o,
  output logic [NPORTS-1:0]      current_limit_trip_o,
  output logic [NPORTS-1:0]      detect_restart_o
);
  import fault_timing_pkg::*;

  // ---------------------------------------------------------------
  // Register access
  // ---------------------------------------------------------------
  logic [7:0] fault_timeout_config;
  logic [7:0] next_config;
  wire        cmd_hit   = cmd_valid_i
                          && (cmd_code_i == FAULT_TIMEOUT_CONFIG_CMD);
  wire        cfg_write = cmd_hit && cmd_write_i;
  wire [1:0]  lim_code  = fault_timeout_config[CURRENT_LIMIT_CODE_LSB +: 2];
  wire [1:0]  new_lim   = cmd_wdata_i[CURRENT_LIMIT_CODE_LSB +: 2];
  wire        lim_changed = cfg_write && (new_lim != lim_code);

  assign next_config = cfg_write ? cmd_wdata_i : fault_timeout_config;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      fault_timeout_config <= FAULT_TIMEOUT_CONFIG_RST;
      rsp_valid_o          <= 1'b0;
      rsp_rdata_o          <= 8'h00;
    end else begin
      fault_timeout_config <= next_config;
      rsp_valid_o          <= cmd_hit && !cmd_write_i;
      rsp_rdata_o          <= cmd_hit ? fault_timeout_config : 8'h00;
    end
  end

  // Codes leave from flops, same edge as the register
  wire [1:0] next_lim_code   = next_config[CURRENT_LIMIT_CODE_LSB +: 2];
  wire [1:0] next_start_code = next_config[STARTUP_CODE_LSB +: 2];
  wire [1:0] next_ovld_code  = next_config[OVERLOAD_CODE_LSB +: 2];
  wire [1:0] next_drop_code  = next_config[DROPOUT_CODE_LSB +: 2];
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      current_limit_timeout_code_o     <= 2'h0;
      startup_timeout_code_o           <= 2'h0;
      overload_timeout_code_o          <= 2'h0;
      signature_dropout_timeout_code_o <= 2'h0;
    end else begin
      current_limit_timeout_code_o     <= next_lim_code;
      startup_timeout_code_o           <= next_start_code;
      overload_timeout_code_o          <= next_ovld_code;
      signature_dropout_timeout_code_o <= next_drop_code;
    end
  end

  // ---------------------------------------------------------------
  // Timer tick and shared limit
  // ---------------------------------------------------------------
  logic [TICK_CNT_W-1:0] tick_cnt;
  wire  tick = (tick_cnt == TICK_CNT_W'(TICK_CYC - 1));

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) tick_cnt <= '0;
    else       tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
  end

  logic [LIM_CNT_W-1:0] lim_ticks;
  always_comb begin
    case (lim_code)
      2'h0:    lim_ticks = LIM_TICKS0;
      2'h1:    lim_ticks = LIM_TICKS1;
      2'h2:    lim_ticks = LIM_TICKS2;
      default: lim_ticks = LIM_TICKS3;
    endcase
  end

  // ---------------------------------------------------------------
  // Fast shutdown pin synchroniser
  // ---------------------------------------------------------------
  logic oss_meta;
  logic oss_sync;
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      oss_meta <= 1'b0;
      oss_sync <= 1'b0;
    end else begin
      oss_meta <= fast_shutdown_input_i;
      oss_sync <= oss_meta;
    end
  end

  // ---------------------------------------------------------------
  // Per-port timers, all driven by the one shared limit
  // ---------------------------------------------------------------
  genvar p;
  generate
    for (p = 0; p < NPORTS; p++) begin : g_port
      logic [LIM_CNT_W-1:0]  cnt;
      logic [3:0]            decay_pre;
      logic [COOL_CNT_W-1:0] cool;
      logic [LIM_CNT_W-1:0]  next_cnt;
      logic [COOL_CNT_W-1:0] next_cool;

      wire off_evt   = enable_off_cmd_i[p] || port_reset_cmd_i[p]
                       || dc_disconnect_i[p]
                       || (oss_sync && shutdown_priority_i[p]);
      wire counting  = port_power_enable_bit_o[p] && startup_done_i[p]
                       && at_current_limit_i[p];
      wire inc       = tick && counting;
      wire trip      = inc && ((cnt + 1'b1) >= lim_ticks);
      wire decay     = tick && !at_current_limit_i[p]
                       && (decay_pre == 4'(DECAY_DIVIDE - 1))
                       && (cnt != '0);
      wire restart   = lim_changed && (cnt != '0);
      wire cancel    = port_reset_cmd_i[p]
                       || off_or_manual_mode_i[p];
      wire cool_done = tick && (cool == COOL_CNT_W'(1)) && !cancel;
      wire fault_any = trip || overload_fault_i[p] || dropout_fault_i[p]
                       || startup_fault_i[p];

      always_comb begin
        if (off_evt || restart || trip)
          next_cnt = '0;
        else if (inc)
          next_cnt = cnt + 1'b1;
        else if (decay)
          next_cnt = cnt - 1'b1;
        else
          next_cnt = cnt;
      end

      always_comb begin
        if (cancel)
          next_cool = '0;
        else if (trip)
          next_cool = COOL_CNT_W'(COOL_TICKS);
        else if (tick && (cool != '0))
          next_cool = cool - 1'b1;
        else
          next_cool = cool;
      end

      always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
          cnt       <= '0;
          decay_pre <= 4'h0;
          cool      <= '0;
        end else begin
          cnt       <= next_cnt;
          decay_pre <= (off_evt || inc) ? 4'h0
                       : (tick ? decay_pre + 1'b1 : decay_pre);
          cool      <= next_cool;
        end
      end

      // Fault wins over a same-cycle power-on request
      always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
          port_power_enable_bit_o[p] <= 1'b0;
          port_power_good_bit_o[p]   <= 1'b0;
          cool_down_active_o[p]      <= 1'b0;
          current_limit_trip_o[p]    <= 1'b0;
          detect_restart_o[p]        <= 1'b0;
        end else begin
          if (fault_any || off_evt)
            port_power_enable_bit_o[p] <= 1'b0;
          else if (power_on_req_i[p] && (cool == '0) && !trip)
            port_power_enable_bit_o[p] <= 1'b1;
          if (fault_any || off_evt || !port_power_enable_bit_o[p])
            port_power_good_bit_o[p] <= 1'b0;
          else
            port_power_good_bit_o[p] <= power_good_sense_i[p];
          cool_down_active_o[p]   <= (next_cool != '0);
          current_limit_trip_o[p] <= trip;
          detect_restart_o[p]     <= cool_done
                                     && semiauto_detect_en_i[p];
        end
      end
    end
  endgenerate

endmodule

// >>> testbench/fault_timing_properties.sv
// Port checks for the fault-timing block
`timescale 1ns/1ps
module fault_timing_properties
  import fault_timing_pkg::*;
#(parameter int NPORTS = 4) (
  // Watched ports
  input wire logic              ref_clk_i,
  input wire logic              rst_i,
  input wire logic              cmd_valid_i,
  input wire logic [7:0]        cmd_code_i,
  input wire logic              cmd_write_i,
  input wire logic              rsp_valid_o,
  input wire logic [NPORTS-1:0] overload_fault_i,
  input wire logic [NPORTS-1:0] off_or_manual_mode_i,
  input wire logic [NPORTS-1:0] port_power_good_bit_o,
  input wire logic [NPORTS-1:0] port_power_enable_bit_o,
  input wire logic [NPORTS-1:0] cool_down_active_o,
  input wire logic [NPORTS-1:0] current_limit_trip_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  wire rd = cmd_valid_i && !cmd_write_i
            && cmd_code_i == FAULT_TIMEOUT_CONFIG_CMD;
  AST_READ_ANSWER: assert property (rd |=> rsp_valid_o)
    else $error("read not answered");
  AST_NO_STRAY: assert property (!rd |=> !rsp_valid_o)
    else $error("answer without read");
  AST_FAULT_OFF: assert property (|overload_fault_i |=>
    (port_power_enable_bit_o & $past(overload_fault_i)) == '0)
    else $error("fault left port enabled");
  AST_PG_NEEDS_EN: assert property (
    (port_power_good_bit_o & ~port_power_enable_bit_o) == '0)
    else $error("power good without enable");
  AST_TRIP_OFF: assert property (|current_limit_trip_o |->
    (current_limit_trip_o & port_power_enable_bit_o) == '0)
    else $error("tripped port still enabled");
  AST_TRIP_COOL: assert property (|current_limit_trip_o |->
    (current_limit_trip_o & ~cool_down_active_o) == '0)
    else $error("trip without cool-down");
  AST_COOL_NO_POWER: assert property (
    (cool_down_active_o & port_power_enable_bit_o) == '0)
    else $error("power on during cool-down");
  AST_CANCEL: assert property (
    (cool_down_active_o & $past(off_or_manual_mode_i)) == '0)
    else $error("cool-down not cancelled");
  cover property (rd);
  cover property (|current_limit_trip_o);
  cover property (|(cool_down_active_o & off_or_manual_mode_i));
endmodule

bind pse_port_fault_timing fault_timing_properties #(.NPORTS(NPORTS)) props (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i),
  .cmd_code_i(cmd_code_i), .cmd_write_i(cmd_write_i),
  .rsp_valid_o(rsp_valid_o), .overload_fault_i(overload_fault_i),
  .off_or_manual_mode_i(off_or_manual_mode_i),
  .port_power_good_bit_o(port_power_good_bit_o),
  .port_power_enable_bit_o(port_power_enable_bit_o),
  .cool_down_active_o(cool_down_active_o),
  .current_limit_trip_o(current_limit_trip_o));

// >>> testbench/mgmt_host.sv
// Host model driving the management command port
`timescale 1ns/1ps
module mgmt_host (
  // Command port
  input  wire logic       ref_clk_i,
  output logic            cmd_valid_o,
  output logic [7:0]      cmd_code_o,
  output logic            cmd_write_o,
  output logic [7:0]      cmd_wdata_o
);
  initial {cmd_valid_o, cmd_write_o, cmd_code_o, cmd_wdata_o} = '0;
  // One byte per access; lines scrambled once released
  task automatic access(input logic w, input logic [7:0] c, d);
    @(negedge ref_clk_i);
    cmd_valid_o <= 1'b1;
    cmd_write_o <= w;
    cmd_code_o <= c;
    cmd_wdata_o <= d;
    @(negedge ref_clk_i);
    cmd_valid_o <= 1'b0;
    cmd_code_o <= ~c;
    cmd_wdata_o <= ~d;
  endtask
endmodule

// >>> testbench/tb_top.sv
// Self-checking bench for the port fault-timing block
`timescale 1ns/1ps
module tb_top;
  import fault_timing_pkg::*;
  localparam int T = 4;
  localparam int C = 20;
  logic       clk, rst, cv, cw, rv, fsd;
  logic [7:0] cc, cd, rdat, v, exp_q[$];
  logic [1:0] cl, st, ov, dr;
  logic [3:0] pon, pgs, sdn, lim, ovf, dof, stf, eoff, prst, dcd, shp;
  logic [3:0] mode, sem, pg, pe, cool, trp, rs;
  int         n_errors = 0, total_checks = 0, cyc = 0, n;
  // -------------------------------------------------------------
  // Short counts keep the run brief
  // -------------------------------------------------------------
  pse_port_fault_timing #(.TICK_CYC(T), .COOL_TICKS(C),
    .LIM_TICKS0(12'd8), .LIM_TICKS1(12'd6), .LIM_TICKS2(12'd4),
    .LIM_TICKS3(12'd3)) DUT (.ref_clk_i(clk), .rst_i(rst),
    .cmd_valid_i(cv), .cmd_code_i(cc), .cmd_write_i(cw),
    .cmd_wdata_i(cd), .rsp_valid_o(rv), .rsp_rdata_o(rdat),
    .current_limit_timeout_code_o(cl), .startup_timeout_code_o(st),
    .overload_timeout_code_o(ov), .signature_dropout_timeout_code_o(dr),
    .power_on_req_i(pon), .power_good_sense_i(pgs), .startup_done_i(sdn),
    .at_current_limit_i(lim), .overload_fault_i(ovf),
    .dropout_fault_i(dof), .startup_fault_i(stf), .enable_off_cmd_i(eoff),
    .port_reset_cmd_i(prst), .dc_disconnect_i(dcd),
    .shutdown_priority_i(shp), .off_or_manual_mode_i(mode),
    .semiauto_detect_en_i(sem), .fast_shutdown_input_i(fsd),
    .port_power_good_bit_o(pg), .port_power_enable_bit_o(pe),
    .cool_down_active_o(cool), .current_limit_trip_o(trp),
    .detect_restart_o(rs));
  mgmt_host host (.ref_clk_i(clk), .cmd_valid_o(cv), .cmd_code_o(cc),
    .cmd_write_o(cw), .cmd_wdata_o(cd));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input string s, input logic [7:0] e, g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic rd(input logic [7:0] e);
    exp_q.push_back(e);
    host.access(1'b0, FAULT_TIMEOUT_CONFIG_CMD, 8'h00);
  endtask
  // Bounded wait on port 0 trip or detect restart
  task automatic wait_for(input logic r);
    n = 0;
    while ((r ? rs[0] : trp[0]) !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic close_out();
    if (exp_q.size() != 0) n_errors++;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(negedge clk) begin
    if (rv === 1'b1) begin
      if (exp_q.size() == 0) chk("answer count", 8'h00, 8'h01);
      else chk("read data", exp_q.pop_front(), rdat);
    end
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      close_out();
    end
  end
  initial begin
    {pon, pgs, sdn, lim, ovf, dof, stf, eoff, prst, dcd, shp} = '0;
    {mode, sem, fsd, rst} = 10'h001;
    void'($urandom(32'h1308348d));
    repeat (8) @(negedge clk);
    rst = 1'b0;
    rd(8'h00);
    for (int i = 0; i < 6; i++) begin
      v = 8'($urandom);
      host.access(1'b1, FAULT_TIMEOUT_CONFIG_CMD, v);
      chk("codes", v, {cl, st, ov, dr});
      rd(v);
    end
    host.access(1'b1, 8'h15, 8'h5a);
    host.access(1'b0, 8'h15, 8'h00);
    rd(v);
    host.access(1'b1, FAULT_TIMEOUT_CONFIG_CMD, 8'hc0);
    {pon, pgs, sdn, sem} = 16'h3f3f;
    repeat (3) @(negedge clk);
    chk("power on", 8'h03, {4'h0, pe});
    for (int k = 0; k < 3; k++) begin
      {ovf[1], dof[1], stf[1]} = 3'b100 >> k;
      @(negedge clk);
      {ovf[1], dof[1], stf[1]} = 3'b000;
      chk("fault off", 8'h00, {6'h0, pe[1], pg[1]});
      repeat (3) @(negedge clk);
    end
    lim[0] = 1'b1;
    wait_for(1'b0);
    chk("trip time", 8'h01, 8'(n >= 2*T && n <= 4*T + 1));
    chk("enables", 8'h02, {4'h0, pe});
    wait_for(1'b1);
    chk("cool time", 8'h01, 8'(n >= (C-2)*T && n <= (C+2)*T));
    host.access(1'b1, FAULT_TIMEOUT_CONFIG_CMD, 8'h00);
    repeat (5*T) @(negedge clk);
    eoff[0] = 1'b1;
    @(negedge clk);
    eoff[0] = 1'b0;
    wait_for(1'b0);
    chk("cleared count", 8'h01, 8'(n >= 7*T && n <= 11*T));
    {lim[0], mode[0]} = 2'b01;
    repeat (2) @(negedge clk);
    chk("cancel", 8'h00, {7'h0, cool[0]});
    mode[0] = 1'b0;
    repeat (4*T) @(negedge clk);
    close_out();
  end
endmodule
